// ===== rtl/otd_pkg.sv
// Constants for the transmit-disable control block
package otd_pkg;
  // ----------------------------------------------------------------
  // Serial memory map
  // ----------------------------------------------------------------
  localparam logic [6:0] OTD_DEV_ADDR   = 7'h51;   // 8-bit form A2h
  localparam logic [7:0] OTD_REG_STATUS = 8'h6e;   // diag_status_control
  localparam int         OTD_BIT_DIS    = 7;       // shutdown state, read only
  localparam int         OTD_BIT_SOFT   = 6;       // software shutdown, read/write
  localparam int         OTD_BIT_FAULT  = 2;       // latched laser fault, read only
  localparam logic       OTD_SOFT_RST   = 1'b0;
  localparam logic [7:0] OTD_BYTE_ZERO  = 8'h00;
  localparam logic [7:0] OTD_PTR_STEP   = 8'h01;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  localparam logic [3:0] OTD_BITS_BYTE  = 4'h8;
  localparam logic [3:0] OTD_BIT_ZERO   = 4'h0;
  localparam logic [3:0] OTD_BIT_ONE    = 4'h1;
  localparam logic [3:0] OTD_BIT_STEP   = 4'h1;
  localparam logic [1:0] OTD_BOOT_DONE  = 2'h3;

  typedef enum logic [2:0] {
    OTD_IDLE = 3'b000,
    OTD_DEV  = 3'b001,
    OTD_PTR  = 3'b010,
    OTD_WDAT = 3'b011,
    OTD_DACK = 3'b100,
    OTD_RDAT = 3'b101,
    OTD_RACK = 3'b110
  } otd_state_t;
endpackage : otd_pkg

// ===== rtl/otd_sync.sv
// Two-stage synchroniser with a constant reset level
`timescale 1ns/1ps
module otd_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : otd_sync

// ===== rtl/otd_ctrl.sv
// Transmit-disable control with serial status/control byte
//
// Behaviour
// - Laser output off while shutdown pin high, normal while low.
// - Cycling the shutdown request clears a latched fault.
// - Undriven shutdown pin counts as asserted; laser off from reset.
// - Software shutdown bit 6 of byte 110 at A2h, honoured.
// - Bit 7 of byte 110 reports the shutdown state.
// - Effective shutdown is pin OR software bit.
// - Laser fault disables laser, latches fault pin, readable bit 2.
`timescale 1ns/1ps
module otd_ctrl
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic tx_disable_in,
  input  wire logic laser_fault_in,
  input  wire logic scl_in,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      tx_fault_o,
  output logic      tx_fault_oe,
  output logic      laser_enable
);
  import otd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic dis_q;
  logic fault_q;
  logic scl_q;
  logic sda_q;

  // Reset level high keeps the laser dark until the pin is really seen
  otd_sync #(.RST_VAL(1'b1)) u_sync_dis (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       (tx_disable_in),
    .q       (dis_q)
  );
  otd_sync #(.RST_VAL(1'b0)) u_sync_flt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       (laser_fault_in),
    .q       (fault_q)
  );
  otd_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       (scl_in),
    .q       (scl_q)
  );
  otd_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       (sda_i),
    .q       (sda_q)
  );

  // ----------------------------------------------------------------
  // Disable and fault control
  // ----------------------------------------------------------------
  logic soft_dis;
  logic next_soft_dis;
  logic fault_lat;
  logic next_fault_lat;
  logic eff_prev;
  logic eff_dis;
  logic eff_rise;
  logic wr_en;
  logic [7:0] sh;

  assign eff_dis  = dis_q | soft_dis;
  assign eff_rise = eff_dis & ~eff_prev;

  always_comb begin
    next_soft_dis  = soft_dis;
    if (wr_en) begin
      next_soft_dis = sh[OTD_BIT_SOFT];
    end
    // Set wins over the clear, so a live fault is never lost
    next_fault_lat = fault_q | (fault_lat & ~eff_rise);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_dis     <= OTD_SOFT_RST;
      fault_lat    <= 1'b0;
      eff_prev     <= 1'b1;
      laser_enable <= 1'b0;
      tx_fault_oe  <= 1'b1;
      tx_fault_o   <= 1'b0;
    end else begin
      soft_dis     <= next_soft_dis;
      fault_lat    <= next_fault_lat;
      eff_prev     <= eff_dis;
      laser_enable <= ~eff_dis & ~fault_lat;
      tx_fault_oe  <= ~fault_lat;
      tx_fault_o   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Two-wire serial slave
  // ----------------------------------------------------------------
  otd_state_t st;
  otd_state_t next_st;
  otd_state_t after;
  otd_state_t next_after;
  logic       scl_d;
  logic       sda_d;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] next_sh;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [7:0] txsh;
  logic [7:0] next_txsh;
  logic       next_sda_oe;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       load_rd;
  logic [7:0] rd_byte;

  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign start_c  = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_c   = scl_q & scl_d & ~sda_d & sda_q;
  // Unimplemented bytes read as zero and ignore writes
  assign rd_byte  = (ptr == OTD_REG_STATUS) ?
                    (OTD_BYTE_ZERO | ({7'h00, eff_dis} << OTD_BIT_DIS)
                                   | ({7'h00, soft_dis} << OTD_BIT_SOFT)
                                   | ({7'h00, fault_lat} << OTD_BIT_FAULT))
                    : OTD_BYTE_ZERO;

  always_comb begin
    next_st     = st;
    next_after  = after;
    next_cnt    = cnt;
    next_sh     = sh;
    next_ptr    = ptr;
    next_txsh   = txsh;
    next_sda_oe = sda_oe;
    wr_en       = 1'b0;
    load_rd     = 1'b0;
    if (start_c) begin
      next_st     = OTD_DEV;
      next_cnt    = OTD_BIT_ZERO;
      next_sda_oe = 1'b0;
    end else if (stop_c) begin
      next_st     = OTD_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (st)
        OTD_IDLE: begin
          next_sda_oe = 1'b0;
        end
        OTD_DEV, OTD_PTR, OTD_WDAT: begin
          if (scl_rise) begin
            next_sh  = {sh[6:0], sda_q};
            next_cnt = cnt + OTD_BIT_STEP;
          end else if (scl_fall && cnt == OTD_BITS_BYTE) begin
            next_cnt    = OTD_BIT_ZERO;
            next_sda_oe = 1'b1;
            next_st     = OTD_DACK;
            if (st == OTD_DEV) begin
              next_after = sh[0] ? OTD_RDAT : OTD_PTR;
              if (sh[7:1] != OTD_DEV_ADDR) begin
                next_sda_oe = 1'b0;
                next_st     = OTD_IDLE;
              end
            end else if (st == OTD_PTR) begin
              next_ptr   = sh;
              next_after = OTD_WDAT;
            end else begin
              wr_en      = (ptr == OTD_REG_STATUS);
              next_ptr   = ptr + OTD_PTR_STEP;
              next_after = OTD_WDAT;
            end
          end
        end
        OTD_DACK, OTD_RACK: begin
          if (st == OTD_RACK && scl_rise && sda_q) begin
            next_st = OTD_IDLE;
          end else if (scl_fall) begin
            if (st == OTD_RACK || after == OTD_RDAT) begin
              load_rd     = 1'b1;
              next_txsh   = rd_byte;
              next_sda_oe = ~rd_byte[7];
              next_ptr    = ptr + OTD_PTR_STEP;
              next_cnt    = OTD_BIT_ONE;
              next_st     = OTD_RDAT;
            end else begin
              next_sda_oe = 1'b0;
              next_st     = after;
            end
          end
        end
        OTD_RDAT: begin
          if (scl_fall) begin
            if (cnt == OTD_BITS_BYTE) begin
              next_sda_oe = 1'b0;
              next_st     = OTD_RACK;
            end else begin
              next_sda_oe = ~txsh[6];
              next_txsh   = {txsh[6:0], 1'b0};
              next_cnt    = cnt + OTD_BIT_STEP;
            end
          end
        end
        default: begin
          next_st     = OTD_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st     <= OTD_IDLE;
      after  <= OTD_IDLE;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
      cnt    <= OTD_BIT_ZERO;
      sh     <= OTD_BYTE_ZERO;
      ptr    <= OTD_BYTE_ZERO;
      txsh   <= OTD_BYTE_ZERO;
      sda_oe <= 1'b0;
      sda_o  <= 1'b0;
    end else begin
      st     <= next_st;
      after  <= next_after;
      scl_d  <= scl_q;
      sda_d  <= sda_q;
      cnt    <= next_cnt;
      sh     <= next_sh;
      ptr    <= next_ptr;
      txsh   <= next_txsh;
      sda_oe <= next_sda_oe;
      sda_o  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [1:0] boot_cnt;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_cnt <= 2'h0;
    end else if (boot_cnt != OTD_BOOT_DONE) begin
      boot_cnt <= boot_cnt + 2'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence fault_seen_s;
    fault_q;
  endsequence
  sequence fault_out_s;
    fault_lat ##1 (!laser_enable && !tx_fault_oe);
  endsequence

  pin_shuts_laser_a: assert property (dis_q |=> !laser_enable)
    else $error("laser on while shutdown pin high");
  soft_or_pin_a: assert property (eff_dis |=> !laser_enable)
    else $error("laser on while effective shutdown set");
  boot_dark_a: assert property ((boot_cnt != OTD_BOOT_DONE) |-> !laser_enable)
    else $error("laser on before pin was sampled");
  toggle_clears_a: assert property (eff_rise && !fault_q |=> !fault_lat)
    else $error("fault not cleared by shutdown toggle");
  fault_latch_a: assert property (fault_seen_s |=> fault_out_s)
    else $error("fault did not latch and disable laser");
  fault_hold_a: assert property (fault_lat && !eff_rise |=> fault_lat)
    else $error("fault latch dropped without toggle");
  soft_write_a: assert property (wr_en |=> soft_dis == $past(sh[OTD_BIT_SOFT]))
    else $error("software shutdown write lost");
  soft_stable_a: assert property (!wr_en |=> $stable(soft_dis))
    else $error("software shutdown changed without write");
  status_read_a: assert property (load_rd && ptr == OTD_REG_STATUS |=>
                                  txsh[OTD_BIT_DIS] == $past(eff_dis))
    else $error("status byte shutdown bit wrong");
endmodule : otd_ctrl

// ===== verif/otd_host_model.sv
// Host board model: serial master for the status/control byte
`timescale 1ns/1ps
module otd_host_model #(
  parameter int HALF = 8
) (
  input  wire logic sys_clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  // ----------------------------------------------------------------
  // Serial bit engine
  // ----------------------------------------------------------------
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Data moves two clocks after SCL falls, never mistaken for START/STOP
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    r = sda_in;
    scl <= 1'b0;
    tick(2);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask : byte_io

  // Works from idle and as a repeated start
  task automatic start_c();
    sda_pull <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(2);
  endtask : start_c

  task automatic stop_c();
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask : stop_c
endmodule : otd_host_model

// ===== verif/testbench.sv
// Self-checking bench for the transmit-disable control block
`timescale 1ns/1ps
module testbench;
  import otd_pkg::*;
  // ----------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------
  logic sys_clk;
  logic rst_b;
  logic pin_en;
  logic pin_val;
  logic laser_fault_in;
  logic scl;
  logic host_pull;
  logic sda_o;
  logic sda_oe;
  logic tx_fault_o;
  logic tx_fault_oe;
  logic laser_enable;
  int   err_total;
  int   total_checks;
  // Pull-ups on the shared lines
  wire  sda_line   = ~((sda_oe & ~sda_o) | host_pull);
  wire  pin_line   = pin_en ? pin_val : 1'b1;
  wire  fault_line = ~(tx_fault_oe & ~tx_fault_o);

  always #12.5 sys_clk = ~sys_clk;

  otd_ctrl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .tx_disable_in(pin_line),
    .laser_fault_in(laser_fault_in), .scl_in(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .tx_fault_o(tx_fault_o), .tx_fault_oe(tx_fault_oe),
    .laser_enable(laser_enable));
  otd_host_model host_u (.sys_clk(sys_clk), .sda_in(sda_line), .scl(scl),
    .sda_pull(host_pull));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic send_x(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    host_u.byte_io(b, 1'b1, rx, ack);
    chk("ack", {7'h00, exp_ack}, {7'h00, ack});
  endtask : send_x

  task automatic send(input logic [7:0] b);
    send_x(b, 1'b0);
  endtask : send

  task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
    host_u.start_c();
    send({OTD_DEV_ADDR, 1'b0});
    send(a);
    send(d);
    host_u.stop_c();
  endtask : wr_at

  task automatic wr_reg(input logic [7:0] d);
    wr_at(OTD_REG_STATUS, d);
  endtask : wr_reg

  // Second byte comes from the auto-incremented pointer, an unused byte
  task automatic rd_two(input logic [7:0] exp);
    logic [7:0] rx;
    logic [7:0] rx2;
    logic       ack;
    host_u.start_c();
    send({OTD_DEV_ADDR, 1'b0});
    send(OTD_REG_STATUS);
    host_u.start_c();
    send({OTD_DEV_ADDR, 1'b1});
    host_u.byte_io(8'hff, 1'b0, rx, ack);
    host_u.byte_io(8'hff, 1'b1, rx2, ack);
    host_u.stop_c();
    chk("status_byte", exp, rx);
    chk("next_byte", OTD_BYTE_ZERO, rx2);
  endtask : rd_two

  task automatic rd_reg(input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    host_u.start_c();
    send({OTD_DEV_ADDR, 1'b0});
    send(OTD_REG_STATUS);
    host_u.start_c();
    send({OTD_DEV_ADDR, 1'b1});
    host_u.byte_io(8'hff, 1'b1, rx, ack);
    host_u.stop_c();
    chk("status_byte", exp, rx);
  endtask : rd_reg

  task automatic pins(input logic las, input logic flt);
    chk("laser_enable", {7'h00, las}, {7'h00, laser_enable});
    chk("fault_line", {7'h00, flt}, {7'h00, fault_line});
  endtask : pins

  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    results();
  end

  initial begin
    sys_clk        = 1'b0;
    rst_b          = 1'b0;
    pin_en         = 1'b0;
    pin_val        = 1'b0;
    laser_fault_in = 1'b0;
    err_total      = 0;
    total_checks   = 0;
    host_u.tick(12);
    rst_b <= 1'b1;
    host_u.tick(6);
    pins(1'b0, 1'b0);
    rd_reg(8'h80);
    pin_en <= 1'b1;
    host_u.tick(5);
    pins(1'b1, 1'b0);
    rd_reg(8'h00);
    // Read-only fault bit written as one must not stick; bit 7 reads one from the software bit
    wr_reg(8'hc4);
    host_u.tick(3);
    pins(1'b0, 1'b0);
    rd_reg(8'hc0);
    wr_reg(8'h00);
    host_u.tick(5);
    pins(1'b1, 1'b0);
    laser_fault_in <= 1'b1;
    host_u.tick(6);
    pins(1'b0, 1'b1);
    laser_fault_in <= 1'b0;
    host_u.tick(6);
    pins(1'b0, 1'b1);
    rd_reg(8'h04);
    // Only time the pin is driven high in the run; the later reset leaves the pin low
    pin_val <= 1'b1;
    host_u.tick(5);
    pins(1'b0, 1'b0);
    rd_reg(8'h80);
    pin_val <= 1'b0;
    host_u.tick(5);
    pins(1'b1, 1'b0);
    // Mid-run reset with the pin low: dark through the sync delay
    wr_reg(8'h40);
    rst_b <= 1'b0;
    host_u.tick(12);
    pins(1'b0, 1'b0);
    rst_b <= 1'b1;
    host_u.tick(2);
    pins(1'b0, 1'b0);
    host_u.tick(4);
    pins(1'b1, 1'b0);
    rd_reg(8'h00);
    // Foreign device address gets no acknowledge
    host_u.start_c();
    send_x({OTD_DEV_ADDR + 7'h01, 1'b0}, 1'b1);
    host_u.stop_c();
    // Write to a neighbouring byte must not reach the software bit
    wr_at(OTD_REG_STATUS + 8'h01, 8'h40);
    pins(1'b1, 1'b0);
    wr_reg(8'h40);
    host_u.tick(3);
    pins(1'b0, 1'b0);
    rd_two(8'hc0);
    results();
  end
endmodule : testbench
